// >>> dv/cacc_pins_model.sv
// pin-side model: external sources on module pins and count input
`timescale 1ns/1ns
module cacc_pins_model #(
    parameter int NMOD = 5
) (
    input  wire logic            hclk,
    output logic      [NMOD-1:0] pin,     // module pin levels
    output logic                 ext_cnt  // external count input
);
    // sources idle low until a scenario moves them
    initial begin
        pin = '0;
        ext_cnt = 1'b0;
    end
    // move one pin just after an edge, then hold it
    task automatic set_pin(input int n, input logic v);
        @(posedge hclk);
        pin[n] <= v;
    endtask
    // k count pulses; slow stretches each level for a slow source
    task automatic pulses(input int k, input int slow);
        repeat (k) begin
            repeat (2 + slow) @(posedge hclk);
            ext_cnt <= 1'b1;
            repeat (2 + slow) @(posedge hclk);
            ext_cnt <= 1'b0;
        end
    endtask
endmodule

// >>> dv/test_counter_array_capture_compare.sv
// self-checking bench of the counter array block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_counter_array_capture_compare;
    localparam logic [31:0] ONE  = 32'h0000_0001;
    localparam logic [31:0] RUN  = ONE << cacc_pkg::CTRL_RUN_BIT;
    localparam logic [31:0] OVF  = ONE << cacc_pkg::CTRL_OVF_BIT;
    localparam logic [31:0] IRQ  = ONE << cacc_pkg::MODE_IRQ_BIT;
    localparam logic [31:0] PWM  = ONE << cacc_pkg::MODE_PWM_BIT;
    localparam logic [31:0] FLIP = ONE << cacc_pkg::MODE_FLIP_BIT;
    localparam logic [31:0] HIT  = ONE << cacc_pkg::MODE_HIT_BIT;
    localparam logic [31:0] FALL = ONE << cacc_pkg::MODE_FALL_BIT;
    localparam logic [31:0] RISE = ONE << cacc_pkg::MODE_RISE_BIT;
    localparam logic [31:0] CMP  = ONE << cacc_pkg::MODE_CMP_BIT;
    logic        hclk, hresetn, ce, hsel, hwrite, t0, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [4:0]  pin_in, pin_out, oe_n, mirq;
    logic        ext, airq, irq;
    wire logic   hready;             // single slave drives the bus ready
    int          n_mismatch, checks, k, e;
    logic        hit;
    logic [15:0] v, c, exp16;
    logic [7:0]  d [5];
    logic [31:0] modes [3];
    logic [7:0]  regs [8];
    assign hready = hreadyout;
    cacc_top #(.NMOD(5)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .timer0_ovf(t0),
        .ext_count_in(ext), .module_io_pin_in(pin_in),
        .module_io_pin_out(pin_out), .module_io_pin_oe_n(oe_n),
        .module_irq(mirq), .array_irq(airq), .irq(irq));
    cacc_pins_model #(.NMOD(5)) i_pins (.hclk(hclk), .pin(pin_in),
        .ext_cnt(ext));
    // 25 MHz clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // wait for ready at an edge; only the watchdog ends a hang
    task automatic wait_rdy();
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
    endtask
    // one single-word transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        hsize <= 3'b010;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        // let the edge's updates settle before callers look at outputs
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        logic [31:0] x;
        bus(a, 1'b1, dat, x);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(a, 1'b0, 32'h0000_0000, r);
    endtask
    // timer-0 overflow held high for n edges
    task automatic t0p(input int n);
        @(posedge hclk);
        t0 <= 1'b1;
        repeat (n) @(posedge hclk);
        t0 <= 1'b0;
    endtask
    function automatic logic [7:0] ma(input int m);
        return cacc_pkg::ADDR_MODE0 + cacc_pkg::MOD_STRIDE * 8'(m);
    endfunction
    function automatic logic [7:0] ca(input int m);
        return cacc_pkg::ADDR_CAP0 + cacc_pkg::MOD_STRIDE * 8'(m);
    endfunction
    function automatic logic [31:0] src(input cacc_pkg::cacc_src_t s);
        return 32'(s) << cacc_pkg::SRC_SEL_LO_BIT;
    endfunction
    // pwm pin level expected for a counter low byte and duty
    function automatic logic pwm_hi(input logic [7:0] cl, input logic [7:0] dt);
        return cl >= dt;
    endfunction
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog cuts a hung run short
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        $display("[ERR] watchdog ran out");
        finish_test();
    end
    // main sequence
    initial begin
        hresetn = 1'b0; ce = 1'b1; hsel = 1'b1; haddr = '0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = '0; t0 = 1'b0;
        n_mismatch = 0; checks = 0;
        regs = '{cacc_pkg::ADDR_CTRL, cacc_pkg::ADDR_SRC, cacc_pkg::ADDR_CNT,
                 cacc_pkg::ADDR_IRQST, cacc_pkg::ADDR_IRQMSK, ma(4), ca(4),
                 8'h1C};
        modes = '{RISE, FALL, RISE | FALL};
        void'($urandom(82983));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, unmapped place ignores writes
        wr(8'h1C, 32'hFFFF_FFFF);
        foreach (regs[i]) begin
            rd(regs[i]);
            `CHK("reset", 32'(cacc_pkg::RST_WORD), r)
        end
        `CHK("oe_n", 5'h00, oe_n)
        `CHK("hresp", 1'b0, hresp)
        done("reset");
        // fast count across the wrap, overflow flag sticks
        wr(cacc_pkg::ADDR_SRC, src(cacc_pkg::CACC_SRC_DIV4) | ONE);
        wr(cacc_pkg::ADDR_CNT, 32'h0000_FFFD);
        wr(cacc_pkg::ADDR_CTRL, RUN);
        repeat (40) @(posedge hclk);
        wr(cacc_pkg::ADDR_CTRL, OVF);
        rd(cacc_pkg::ADDR_CNT);
        `CHK("wrap", 1'b1, r[15:0] < 16'h0010)
        wr(cacc_pkg::ADDR_CNT, 32'h0000_1234);
        repeat (30) @(posedge hclk);
        rd(cacc_pkg::ADDR_CNT);
        `CHK("halt", 16'h1234, r[15:0])
        rd(cacc_pkg::ADDR_CTRL);
        `CHK("ovf_flag", 1'b1, r[cacc_pkg::CTRL_OVF_BIT])
        `CHK("ovf_irq", 1'b1, airq)
        wr(cacc_pkg::ADDR_CTRL, 32'h0000_0000);
        rd(cacc_pkg::ADDR_CTRL);
        `CHK("ovf_clr", 1'b0, r[cacc_pkg::CTRL_OVF_BIT])
        done("overflow");
        // software timer on module 0 with flip, module 1 without
        v = 16'($urandom_range(32'h0000_FFF0, 32'h0000_0010));
        wr(ca(0), 32'(v));
        wr(ca(1), 32'(v + 16'h0001));
        wr(ma(0), CMP | HIT | FLIP | IRQ);
        wr(ma(1), CMP | HIT);
        wr(cacc_pkg::ADDR_SRC, src(cacc_pkg::CACC_SRC_TMR0));
        wr(cacc_pkg::ADDR_CNT, 32'(v - 16'h0003));
        wr(cacc_pkg::ADDR_CTRL, RUN);
        t0p(6);
        wr(cacc_pkg::ADDR_CTRL, 32'h0000_001F);
        rd(cacc_pkg::ADDR_CNT);
        `CHK("t0_count", v + 16'h0003, r[15:0])
        rd(cacc_pkg::ADDR_CTRL);
        `CHK("hit_flags", 2'b11, r[1:0])
        `CHK("flip", 2'b01, pin_out[1:0])
        `CHK("mod_irq", 2'b01, mirq[1:0])
        `CHK("arr_irq", 1'b1, airq)
        `CHK("masked", 1'b0, irq)
        wr(cacc_pkg::ADDR_IRQMSK, 32'h0000_0003);
        `CHK("unmasked", 1'b1, irq)
        wr(cacc_pkg::ADDR_IRQST, 32'h0000_0003);
        `CHK("st_clr", 1'b0, irq)
        done("compare");
        // capture on modules 2..4: rise, fall, both
        wr(cacc_pkg::ADDR_CTRL, 32'h0000_0000);
        for (k = 2; k < 5; k++) begin
            exp16 = cacc_pkg::RST_WORD;
            wr(ma(k), modes[k - 2] | IRQ);
            for (e = 0; e < 2; e++) begin
                c = 16'($urandom());
                wr(cacc_pkg::ADDR_CNT, 32'(c));
                i_pins.set_pin(k, e == 0);
                repeat (6) @(posedge hclk);
                hit = (modes[k - 2] & (e == 0 ? RISE : FALL)) != 0;
                if (hit) exp16 = c;
                rd(ca(k));
                `CHK("capture", exp16, r[15:0])
                rd(cacc_pkg::ADDR_CTRL);
                `CHK("cap_flag", hit, r[k])
                `CHK("cap_irq", hit, mirq[k])
                wr(cacc_pkg::ADDR_CTRL, 32'h0000_0000);
            end
        end
        done("capture");
        // external count: prompt then slow source
        wr(cacc_pkg::ADDR_SRC, src(cacc_pkg::CACC_SRC_EXT));
        wr(cacc_pkg::ADDR_CNT, 32'h0000_0000);
        wr(cacc_pkg::ADDR_CTRL, RUN);
        i_pins.pulses(5, 0);
        i_pins.pulses(3, 3);
        repeat (6) @(posedge hclk);
        wr(cacc_pkg::ADDR_CTRL, 32'h0000_0000);
        rd(cacc_pkg::ADDR_CNT);
        `CHK("ext_count", 16'h0008, r[15:0])
        wr(cacc_pkg::ADDR_SRC, src(cacc_pkg::CACC_SRC_DIV12));
        wr(cacc_pkg::ADDR_CNT, 32'h0000_0000);
        wr(cacc_pkg::ADDR_CTRL, RUN);
        repeat (120) @(posedge hclk);
        wr(cacc_pkg::ADDR_CTRL, 32'h0000_0000);
        rd(cacc_pkg::ADDR_CNT);
        `CHK("div12", 1'b1, r[15:0] >= 16'h0009 && r[15:0] <= 16'h000B)
        // clock enable low freezes the running counter
        wr(cacc_pkg::ADDR_CNT, 32'h0000_0000);
        wr(cacc_pkg::ADDR_CTRL, RUN);
        @(posedge hclk);
        ce <= 1'b0;
        repeat (100) @(posedge hclk);
        ce <= 1'b1;
        wr(cacc_pkg::ADDR_CTRL, 32'h0000_0000);
        rd(cacc_pkg::ADDR_CNT);
        `CHK("ce_freeze", 1'b1, r[15:0] <= 16'h0001)
        done("sources");
        // pwm on all modules from the one counter
        for (k = 0; k < 5; k++) begin
            d[k] = 8'($urandom_range(32'h0000_00FE, 32'h0000_0001));
            wr(ca(k), 32'({d[k], d[k]}));
            wr(ma(k), PWM | CMP);
        end
        for (e = 0; e < 4; e++) begin
            c = 16'($urandom());
            if (e == 0) c[7:0] = d[0];
            if (e == 1) c[7:0] = d[0] - 8'h01;
            wr(cacc_pkg::ADDR_CNT, 32'(c));
            repeat (4) @(posedge hclk);
            for (k = 0; k < 5; k++) begin
                `CHK("pwm_pin", pwm_hi(c[7:0], d[k]), pin_out[k])
            end
        end
        wr(ca(0), 32'({8'h80, 8'h40}));
        wr(cacc_pkg::ADDR_SRC, src(cacc_pkg::CACC_SRC_TMR0));
        wr(cacc_pkg::ADDR_CNT, 32'h0000_00FF);
        wr(cacc_pkg::ADDR_CTRL, RUN);
        t0p(1);
        wr(cacc_pkg::ADDR_CTRL, 32'h0000_0000);
        rd(ca(0));
        `CHK("reload", 16'h8080, r[15:0])
        `CHK("pwm_dut", pwm_hi(8'h00, 8'h80), pin_out[0])
        done("pwm");
        finish_test();
    end
endmodule

// >>> src/cacc_module.sv
// one capture/compare module of the counter array
`timescale 1ns/1ns
module cacc_module (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic [6:0]  mode,      // module mode bits
    input  wire logic [15:0] count,     // shared counter value
    input  wire logic        tick,      // counter advances this cycle
    input  wire logic        pin_in,    // module pin, asynchronous input
    input  wire logic        wr_lo,     // software write of low byte
    input  wire logic        wr_hi,     // software write of high byte
    input  wire logic [15:0] wdata,     // low byte 7:0, high byte 15:8
    output logic      [7:0]  reg_lo,
    output logic      [7:0]  reg_hi,
    output logic             pin_out,
    output logic             event_p    // one-cycle event pulse
);
    // all module state
    typedef struct packed {
        logic       s1;      // synchroniser first stage
        logic       s2;      // synchroniser second stage
        logic       prev;    // previous sampled level
        logic [7:0] lo;
        logic [7:0] hi;
        logic       out;
        logic       ev;
    } cacc_mod_st_t;
    cacc_mod_st_t st_reg, st_next;
    logic rise, fall, hit, pwm;

    // edge detect, compare, pwm and capture
    always_comb begin
        st_next = st_reg;
        st_next.ev = 1'b0;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.prev = st_reg.s2;
        rise = st_reg.s2 & ~st_reg.prev;
        fall = ~st_reg.s2 & st_reg.prev;
        pwm = mode[cacc_pkg::MODE_PWM_BIT] & mode[cacc_pkg::MODE_CMP_BIT];
        hit = mode[cacc_pkg::MODE_CMP_BIT] & ~pwm
            & (count == {st_reg.hi, st_reg.lo});
        if (wr_lo) begin
            st_next.lo = wdata[7:0];
        end
        if (wr_hi) begin
            st_next.hi = wdata[15:8];
        end
        // capture on selected edge
        if ((rise & mode[cacc_pkg::MODE_RISE_BIT])
            | (fall & mode[cacc_pkg::MODE_FALL_BIT])) begin
            st_next.lo = count[7:0];
            st_next.hi = count[15:8];
            st_next.ev = 1'b1;
        end
        // compare hit, once per count
        if (hit & tick & mode[cacc_pkg::MODE_HIT_BIT]) begin
            st_next.ev = 1'b1;
            if (mode[cacc_pkg::MODE_FLIP_BIT]) begin
                st_next.out = ~st_reg.out;
            end
        end
        if (pwm) begin
            st_next.out = (count[7:0] >= st_reg.lo);
            if (tick & (count[7:0] == 8'hFF)) begin
                st_next.lo = st_reg.hi;
            end
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign reg_lo  = st_reg.lo;
    assign reg_hi  = st_reg.hi;
    assign pin_out = st_reg.out;
    assign event_p = st_reg.ev;
endmodule

// >>> src/cacc_pkg.sv
// package: register map, field positions and modes of the counter array
package cacc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00; // array_ctrl_flags
    localparam logic [7:0] ADDR_SRC    = 8'h04; // array_source_reg
    localparam logic [7:0] ADDR_CNT    = 8'h08; // counter high and low bytes
    localparam logic [7:0] ADDR_IRQST  = 8'h0C; // sticky interrupt status
    localparam logic [7:0] ADDR_IRQMSK = 8'h10; // interrupt mask
    localparam logic [7:0] ADDR_MODE0  = 8'h20; // module_mode_reg, step 8
    localparam logic [7:0] ADDR_CAP0   = 8'h24; // module capture regs, step 8
    localparam logic [7:0] MOD_STRIDE  = 8'h08; // spacing between modules
    // control/flag fields
    localparam int CTRL_OVF_BIT  = 7; // counter_overflow_flag
    localparam int CTRL_RUN_BIT  = 6; // count_run_enable
    // source register fields
    localparam int SRC_OVF_IE_BIT = 0; // overflow_irq_enable
    localparam int SRC_SEL_LO_BIT = 1; // count_source_sel_lo
    localparam int SRC_SEL_HI_BIT = 2; // count_source_sel_hi
    // module mode fields
    localparam int MODE_IRQ_BIT  = 0; // module_irq_enable
    localparam int MODE_PWM_BIT  = 1; // pwm enable
    localparam int MODE_FLIP_BIT = 2; // output_flip_on_hit
    localparam int MODE_HIT_BIT  = 3; // compare_hit_flag_enable
    localparam int MODE_FALL_BIT = 4; // falling_capture_enable
    localparam int MODE_RISE_BIT = 5; // rising_capture_enable
    localparam int MODE_CMP_BIT  = 6; // comparator_enable
    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    // prescale divisors of the oscillator
    localparam logic [3:0] DIV12_LAST = 4'h0B;
    localparam logic [3:0] DIV4_LAST  = 4'h3;
    // count source encodings
    typedef enum logic [1:0] {
        CACC_SRC_DIV12 = 2'b00,
        CACC_SRC_DIV4  = 2'b01,
        CACC_SRC_TMR0  = 2'b10,
        CACC_SRC_EXT   = 2'b11
    } cacc_src_t;
endpackage

// >>> src/cacc_top.sv
// counter array top: shared counter, five modules, AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
// Behaviour
// - capture on enabled rising/falling pin edges
// - capture copies counter, sets module flag
// - module irq needs flag and enable
// - compare match sets module flag
// - match toggles output when flip and hit flag enabled
// - pwm low below compare, else high
// - pwm reload low from high at wrap
// - all modules use one shared counter
// - per-module and shared interrupt sources
// - counter runs only while run enabled
// - overflow sets flag, only software clears
// - two select bits choose count source
// - module flags stay until software clears
module cacc_top #(
    parameter int NMOD = 5
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              timer0_ovf,   // timer-0 overflow pulse
    input  wire logic              ext_count_in, // external_count_input
    input  wire logic [NMOD-1:0]   module_io_pin_in,
    output logic      [NMOD-1:0]   module_io_pin_out,
    output logic      [NMOD-1:0]   module_io_pin_oe_n,
    output logic      [NMOD-1:0]   module_irq,   // per-module sources
    output logic                   array_irq,    // shared source
    output logic                   irq           // masked status level
);
    // all top-level state
    typedef struct packed {
        logic            wr_pend;  // write data phase pending
        logic [7:0]      waddr;    // latched write address
        logic [31:0]     rdata;
        logic            run;      // count_run_enable
        logic            ovf;      // counter_overflow_flag
        logic [2:0]      src;      // source sel and overflow irq enable
        logic [15:0]     cnt;      // shared counter
        logic [3:0]      pre;      // oscillator prescaler
        logic            e1;       // external input synchroniser
        logic            e2;
        logic            e3;
        logic [NMOD-1:0] flags;    // module_event_flag
        logic [NMOD*7-1:0] modes;  // module_mode_reg
        logic [5:0]      ist;      // sticky status: modules, overflow
        logic [5:0]      imsk;
        logic [3:0]      gap;      // cycles since a divide-by-12 tick
        logic            gap_ok;   // gap counts from a real tick
    } cacc_st_t;
    cacc_st_t st_reg, st_next;

    logic [NMOD-1:0] ev, wr_lo, wr_hi;
    logic [7:0]      mlo [NMOD];
    logic [7:0]      mhi [NMOD];
    logic            tick, wrap, wen;
    logic [5:0]      events;
    cacc_pkg::cacc_src_t src_sel;

    assign src_sel = cacc_pkg::cacc_src_t'(st_reg.src[2:1]);
    assign wen = st_reg.wr_pend;

    // count source selection and qualified increment
    always_comb begin
        case (src_sel)
            cacc_pkg::CACC_SRC_DIV12:
                tick = (st_reg.pre == cacc_pkg::DIV12_LAST);
            cacc_pkg::CACC_SRC_DIV4:
                tick = (st_reg.pre == cacc_pkg::DIV4_LAST);
            cacc_pkg::CACC_SRC_TMR0:  tick = timer0_ovf;
            cacc_pkg::CACC_SRC_EXT:   tick = st_reg.e2 & ~st_reg.e3;
            default:                  tick = 1'b0;
        endcase
        tick = tick & st_reg.run;
        wrap = tick & (st_reg.cnt == 16'hFFFF);
    end

    // per-module write strobes and instances
    genvar g;
    generate
        for (g = 0; g < NMOD; g++) begin : g_mod
            localparam logic [7:0] MBASE = 8'(g * 8);
            assign wr_lo[g] = wen &
                (st_reg.waddr == cacc_pkg::ADDR_CAP0 + MBASE);
            assign wr_hi[g] = wr_lo[g];
            cacc_module u_mod (
                .hclk    (hclk),
                .hresetn (hresetn),
                .ce      (ce),
                .mode    (st_reg.modes[g*7 +: 7]),
                .count   (st_reg.cnt),
                .tick    (tick),
                .pin_in  (module_io_pin_in[g]),
                .wr_lo   (wr_lo[g]),
                .wr_hi   (wr_hi[g]),
                .wdata   (hwdata[15:0]),
                .reg_lo  (mlo[g]),
                .reg_hi  (mhi[g]),
                .pin_out (module_io_pin_out[g]),
                .event_p (ev[g])
            );
        end
    endgenerate

    assign events = {wrap, ev};

    // read data comes straight from its register
    always_comb begin
        hrdata = st_reg.rdata;
    end

    // next-state: bus, counter, flags, status
    always_comb begin
        logic [31:0] rd;
        logic [7:0]  a;
        rd = 32'h0000_0000;
        a = haddr[7:0];
        st_next = st_reg;
        st_next.wr_pend = 1'b0;
        // prescaler runs on every cycle, whether or not counting is enabled
        if (st_reg.pre == cacc_pkg::DIV12_LAST ||
            (src_sel == cacc_pkg::CACC_SRC_DIV4 &&
             st_reg.pre == cacc_pkg::DIV4_LAST)) begin
            st_next.pre = 4'h0;
        end else begin
            st_next.pre = st_reg.pre + 4'h1;
        end
        // external input synchroniser and edge history
        st_next.e1 = ext_count_in;
        st_next.e2 = st_reg.e1;
        st_next.e3 = st_reg.e2;
        // cycles since the last divide-by-twelve tick, for the checker
        if (src_sel != cacc_pkg::CACC_SRC_DIV12 || !st_reg.run) begin
            st_next.gap    = 4'h0;
            st_next.gap_ok = 1'b0;
        end else if (tick) begin
            st_next.gap    = 4'h0;
            st_next.gap_ok = 1'b1;
        end else begin
            st_next.gap = st_reg.gap + 4'h1;
        end
        if (tick) begin
            st_next.cnt = st_reg.cnt + 16'h0001;
        end
        // software writes in data phase
        if (wen) begin
            case (st_reg.waddr)
                cacc_pkg::ADDR_CTRL: begin
                    st_next.run = hwdata[cacc_pkg::CTRL_RUN_BIT];
                    st_next.ovf = st_reg.ovf &
                        hwdata[cacc_pkg::CTRL_OVF_BIT];
                    st_next.flags = st_reg.flags & hwdata[NMOD-1:0];
                end
                cacc_pkg::ADDR_SRC:    st_next.src = hwdata[2:0];
                cacc_pkg::ADDR_CNT:    st_next.cnt = hwdata[15:0];
                cacc_pkg::ADDR_IRQST:  st_next.ist = st_reg.ist & ~hwdata[5:0];
                cacc_pkg::ADDR_IRQMSK: st_next.imsk = hwdata[5:0];
                default: begin
                    for (int i = 0; i < NMOD; i++) begin
                        if (st_reg.waddr ==
                            cacc_pkg::ADDR_MODE0 + 8'(i * 8)) begin
                            st_next.modes[i*7 +: 7] = hwdata[6:0];
                        end
                    end
                end
            endcase
        end
        // hardware sets win over software clears
        st_next.flags = st_next.flags | ev;
        if (wrap) begin
            st_next.ovf = 1'b1;
        end
        st_next.ist = st_next.ist | events;
        // address phase: latch writes, prepare read data
        if (hsel & hready & htrans[1]) begin
            st_next.wr_pend = hwrite;
            st_next.waddr = a;
            case (a)
                cacc_pkg::ADDR_CTRL:
                    rd = {24'h00_0000, st_reg.ovf, st_reg.run, 1'b0,
                          5'(st_reg.flags)};
                cacc_pkg::ADDR_SRC:    rd = {29'h0, st_reg.src};
                cacc_pkg::ADDR_CNT:    rd = {16'h0000, st_reg.cnt};
                cacc_pkg::ADDR_IRQST:  rd = {26'h0, st_reg.ist};
                cacc_pkg::ADDR_IRQMSK: rd = {26'h0, st_reg.imsk};
                default: begin
                    for (int i = 0; i < NMOD; i++) begin
                        if (a == cacc_pkg::ADDR_MODE0 + 8'(i * 8)) begin
                            rd = {25'h0, st_reg.modes[i*7 +: 7]};
                        end
                        if (a == cacc_pkg::ADDR_CAP0 + 8'(i * 8)) begin
                            rd = {16'h0000, mhi[i], mlo[i]};
                        end
                    end
                end
            endcase
            st_next.rdata = rd;
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // interrupt outputs
    always_comb begin
        for (int i = 0; i < NMOD; i++) begin
            module_irq[i] = st_reg.flags[i]
                & st_reg.modes[i*7 + cacc_pkg::MODE_IRQ_BIT];
        end
        array_irq = (|module_irq) |
            (st_reg.ovf & st_reg.src[cacc_pkg::SRC_OVF_IE_BIT]);
        irq = |(st_reg.ist & st_reg.imsk);
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign module_io_pin_oe_n = {NMOD{1'b0}};

    // a capture or hit shows in its module flag the next cycle
    flag_follows_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && ev[0] |=> st_reg.flags[0])
        else $error("module flag not set after event");
    // overflow flag after counter wrap
    ovf_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && wrap && !wen |=> st_reg.ovf && st_reg.cnt == 16'h0000)
        else $error("overflow flag or wrap wrong");
    // halted counter stands still
    run_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !st_reg.run && !wen |=> $stable(st_reg.cnt))
        else $error("counter moved while halted");
    // module irq tracks flag and enable
    mod_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        module_irq[0] |-> st_reg.flags[0] && st_reg.modes[0])
        else $error("module irq without flag and enable");
    // shared irq follows module irq
    shared_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        |module_irq |-> array_irq)
        else $error("shared irq missing");
    // counter moves only by one per tick
    cnt_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && tick && !wen |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
        else $error("counter step wrong");
    // divide-by-twelve source ticks twelve cycles apart
    div12_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && st_reg.gap_ok && st_reg.run
        && src_sel == cacc_pkg::CACC_SRC_DIV12
        |-> tick == (st_reg.gap == cacc_pkg::DIV12_LAST))
        else $error("prescale gap wrong");
    // pin toggles on a flip hit
    flip_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && $rose(ev[0]) && st_reg.modes[2] && st_reg.modes[3]
        && !st_reg.modes[1] && !st_reg.modes[5] && !st_reg.modes[4]
        |-> module_io_pin_out[0] != $past(module_io_pin_out[0]))
        else $error("output did not toggle");
    // pwm pin of module 0 is high once the low byte reaches its duty
    pwm_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && st_reg.modes[cacc_pkg::MODE_PWM_BIT]
        && st_reg.modes[cacc_pkg::MODE_CMP_BIT]
        |=> module_io_pin_out[0]
            == ($past(st_reg.cnt[7:0]) >= $past(mlo[0])))
        else $error("pwm level wrong");
    // a rising pin on module 2, sampled twice, then captured
    sequence pin2_rise_s;
        ce && !module_io_pin_in[2] ##1 ce && module_io_pin_in[2];
    endsequence
    cap_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pin2_rise_s ##1 ce
        ##1 (ce && st_reg.modes[2*7 + cacc_pkg::MODE_RISE_BIT])
        |=> ev[2])
        else $error("rising pin not captured");
endmodule
